// *** verilog/stream_flags_defs.svh ***
// constants for the stream error-flag block: offsets, fields, resets, timing
// assumes a 32-bit AXI4-Lite register window and a 100 MHz mclk
`ifndef STREAM_FLAGS_DEFS_SVH
`define STREAM_FLAGS_DEFS_SVH
`define ADDR_W          4
`define OFF_CTRL        4'h0
`define OFF_STATUS      4'h4
`define OFF_LEVEL       4'h8
`define CTRL_EN_LSB     0
`define CTRL_GAIN_LSB   4
`define CTRL_RESET      32'h0000_0017
`define FLAG_MISSING    0
`define FLAG_PACKET     1
`define FLAG_DROPPED    2
`define IN_DATA_W       16
`define GAIN_W          4
`define OUT_DATA_W      20
`define FIFO_DEPTH      16
`define FIFO_CNT_W      5
`define IN_PERIOD       4'h4
`define OUT_PERIOD      4'h4
`define PACKET_LEN      4'h4
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`endif

// *** verilog/stream_flags_pkg.sv ***
// types shared by the stream error-flag block
// no surroundings assumed
package stream_flags_pkg;
    typedef logic [2:0] flag_vec_type;
endpackage

// *** verilog/converter_stream_error_flags.sv ***
// stream error flags with full-growth gain stage, output fifo and AXI4-Lite registers
// assumes source and sink logic on mclk; reset pins arrive asynchronously
//
// Contract
// RULE1: flag missing input when no valid sample in a required cycle
// RULE2: after a miss, wait and resume only when valid input arrives
// RULE3: a missed sample changes no output value, only delays output
// RULE4: each flag sticks until cleared, disabled or datapath reset
// RULE5: flag packet error on early or absent last-sample marker
// RULE6: consumer must take each output sample in its cycle, else flag
// RULE7: after an untaken output sample, discard the next one, never stall
// RULE8: combined interrupt is the OR of the three flags
// RULE9: source gives signed samples, one integer bit, range -1.0 to below +1.0
// RULE10: keep full integer growth, no saturation or rescaling
// RULE11: flags cleared or disabled over the programming port with its own reset
// RULE12: disabled flag held low; cleared flag drops at next edge
`timescale 1ns/1ps
`include "stream_flags_defs.svh"

module sample_fifo #(
    parameter int WIDTH = 21,
    parameter int DEPTH = 16
) (
    input  wire logic                         mclk,
    input  wire logic                         sys_rst,
    input  wire logic                         flush,
    input  wire logic                         wrValid,
    output logic                              wrReady,
    input  wire logic [WIDTH-1:0]             wrData,
    output logic                              rdValid,
    input  wire logic                         rdReady,
    output logic [WIDTH-1:0]                  rdData,
    output logic [$clog2(DEPTH+1)-1:0]        level
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_q;
    logic [AW-1:0]    rdPtr_q;
    logic [AW:0]      count_q;
    logic             push;
    logic             pop;

    assign wrReady = (count_q != (AW+1)'(DEPTH));
    assign rdValid = (count_q != '0);
    assign push    = wrValid && wrReady;
    assign pop     = rdValid && rdReady;
    assign rdData  = mem[rdPtr_q];
    assign level   = count_q;

    always_ff @(posedge mclk)
    begin
        if (push)
            mem[wrPtr_q] <= wrData;
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end
        else if (flush)
        begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end
        else
        begin
            if (push)
                wrPtr_q <= wrPtr_q + AW'(1);
            if (pop)
                rdPtr_q <= rdPtr_q + AW'(1);
            count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module converter_stream_error_flags
    import stream_flags_pkg::*;
(
    input  wire logic                     mclk,
    input  wire logic                     sys_rst,
    input  wire logic                     datapath_reset_n,
    input  wire logic                     programming_reset_n,
    input  wire logic                     inValid,
    output logic                          inReady,
    input  wire logic [`IN_DATA_W-1:0]    inData,
    input  wire logic                     input_last_marker,
    output logic                          outValid,
    input  wire logic                     outReady,
    output logic [`OUT_DATA_W-1:0]        outData,
    output logic                          outLast,
    output logic                          missing_input_flag,
    output logic                          packet_length_error_flag,
    output logic                          dropped_output_flag,
    output logic                          combined_irq,
    input  wire logic [31:0]              s_axi_awaddr,
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,
    output logic [1:0]                    s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    input  wire logic [31:0]              s_axi_araddr,
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    output logic [31:0]                   s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready
);
    localparam int FW = `OUT_DATA_W + 1;

    // reset pin synchronisers, three stages, change taken when stages 2 and 3 agree
    logic [1:0]   sync1_q;
    logic [1:0]   sync2_q;
    logic [1:0]   sync3_q;
    logic [1:0]   pinLevel_q;
    logic         dpRst;
    logic         progRst;

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sync1_q    <= 2'h0;
            sync2_q    <= 2'h0;
            sync3_q    <= 2'h0;
            pinLevel_q <= 2'h0;
        end
        else
        begin
            sync1_q <= {programming_reset_n, datapath_reset_n};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            for (int i = 0; i < 2; i++)
                if (sync2_q[i] == sync3_q[i])
                    pinLevel_q[i] <= sync3_q[i];
        end
    end
    assign dpRst   = !pinLevel_q[0];
    assign progRst = !pinLevel_q[1];

    // registers
    logic [31:0]  ctrl_q;
    flag_vec_type flags_q;
    flag_vec_type flags_d;
    flag_vec_type flagSet;
    flag_vec_type flagClr;
    flag_vec_type flagEn;
    logic [`FIFO_CNT_W-1:0] fifoLevel;

    assign flagEn = ctrl_q[`CTRL_EN_LSB +: 3];

    // input side
    logic [3:0]   inCnt_q;
    logic [3:0]   inCnt_d;
    logic         waiting_q;
    logic         waiting_d;
    logic         reqCycle;
    logic         inAccept;
    logic [3:0]   pktCnt_q;
    logic         pktFinal;
    logic         fifoWrReady;
    logic signed [`OUT_DATA_W-1:0] scaled;

    assign reqCycle = (inCnt_q == 4'h0) || waiting_q;
    assign inAccept = inValid && inReady;
    assign pktFinal = (pktCnt_q == `PACKET_LEN - 4'h1);
    // full-width product, no clipping
    assign scaled   = `OUT_DATA_W'(signed'(inData))
                    * `OUT_DATA_W'(signed'(ctrl_q[`CTRL_GAIN_LSB +: `GAIN_W])); // RULE10

    always_comb
    begin
        waiting_d = reqCycle && !inAccept; // RULE2
        if (inAccept)
            inCnt_d = `IN_PERIOD - 4'h1;
        else if (inCnt_q != 4'h0)
            inCnt_d = inCnt_q - 4'h1;
        else
            inCnt_d = 4'h0;
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            inCnt_q   <= 4'h0;
            waiting_q <= 1'b0;
            inReady   <= 1'b0;
        end
        else if (dpRst)
        begin
            inCnt_q   <= 4'h0;
            waiting_q <= 1'b0;
            inReady   <= 1'b0;
        end
        else
        begin
            inCnt_q   <= inCnt_d;
            waiting_q <= waiting_d;
            // ready only in required cycles with room for one more
            inReady   <= (waiting_d || inCnt_d == 4'h0) && (fifoLevel < 5'(`FIFO_DEPTH - 1)); // RULE2
        end
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            pktCnt_q <= 4'h0;
        else if (dpRst)
            pktCnt_q <= 4'h0;
        else if (inAccept)
            pktCnt_q <= (pktFinal || input_last_marker) ? 4'h0 : pktCnt_q + 4'h1;
    end

    // output side
    logic         fifoRdValid;
    logic         fifoPop;
    logic [FW-1:0] fifoRdData;
    logic [3:0]   outCnt_q;
    logic         skipNext_q;
    logic         dropEvt;

    assign fifoPop = fifoRdValid && (outCnt_q == 4'h0);
    assign dropEvt = outValid && !outReady; // RULE6

    sample_fifo #(
        .WIDTH (FW),
        .DEPTH (`FIFO_DEPTH)
    ) u_fifo (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .flush   (dpRst),
        .wrValid (inAccept),
        .wrReady (fifoWrReady),
        .wrData  ({input_last_marker, scaled}), // RULE3
        .rdValid (fifoRdValid),
        .rdReady (fifoPop),
        .rdData  (fifoRdData),
        .level   (fifoLevel)
    );

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            outCnt_q   <= 4'h0;
            skipNext_q <= 1'b0;
            outValid   <= 1'b0;
            outData    <= '0;
            outLast    <= 1'b0;
        end
        else if (dpRst)
        begin
            outCnt_q   <= 4'h0;
            skipNext_q <= 1'b0;
            outValid   <= 1'b0;
            outData    <= '0;
            outLast    <= 1'b0;
        end
        else
        begin
            if (fifoPop)
                outCnt_q <= `OUT_PERIOD - 4'h1;
            else if (outCnt_q != 4'h0)
                outCnt_q <= outCnt_q - 4'h1;
            // discarded sample is popped but never shown
            if (dropEvt)
                skipNext_q <= 1'b1; // RULE7
            else if (fifoPop)
                skipNext_q <= 1'b0;
            outValid <= fifoPop && !skipNext_q && !dropEvt; // RULE7
            if (fifoPop)
            begin
                outData <= fifoRdData[`OUT_DATA_W-1:0];
                outLast <= fifoRdData[FW-1];
            end
        end
    end

    // flags: set beats clear, disable and datapath reset beat both
    always_comb
    begin
        flagSet = '0;
        flagSet[`FLAG_MISSING] = reqCycle && !waiting_q && inReady && !inValid; // RULE1
        flagSet[`FLAG_PACKET]  = inAccept && (input_last_marker != pktFinal); // RULE5
        flagSet[`FLAG_DROPPED] = dropEvt; // RULE6
        flags_d = ((flags_q & ~flagClr) | flagSet) & flagEn; // RULE4 RULE12
        if (dpRst)
            flags_d = '0; // RULE4
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            flags_q      <= '0;
            combined_irq <= 1'b0;
        end
        else
        begin
            flags_q      <= flags_d;
            combined_irq <= |flags_d; // RULE8
        end
    end
    assign missing_input_flag       = flags_q[`FLAG_MISSING];
    assign packet_length_error_flag = flags_q[`FLAG_PACKET];
    assign dropped_output_flag      = flags_q[`FLAG_DROPPED];

    // AXI4-Lite slave
    logic         awHeld_q;
    logic         wHeld_q;
    logic [`ADDR_W-1:0] awAddr_q;
    logic [31:0]  wData_q;
    logic [3:0]   wStrb_q;
    logic         doWrite;

    assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;
    assign flagClr = (doWrite && wStrb_q[0] && awAddr_q == `OFF_STATUS) ? wData_q[2:0] : 3'h0; // RULE11

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            awHeld_q      <= 1'b0;
            wHeld_q       <= 1'b0;
            awAddr_q      <= '0;
            wData_q       <= '0;
            wStrb_q       <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= !awHeld_q && !(s_axi_awvalid && s_axi_awready) && !doWrite;
            s_axi_wready  <= !wHeld_q && !(s_axi_wvalid && s_axi_wready) && !doWrite;
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHeld_q <= 1'b1;
                awAddr_q <= s_axi_awaddr[`ADDR_W-1:0];
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHeld_q  <= 1'b1;
                wData_q  <= s_axi_wdata;
                wStrb_q  <= s_axi_wstrb;
            end
            if (doWrite)
            begin
                awHeld_q     <= 1'b0;
                wHeld_q      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awAddr_q == `OFF_CTRL || awAddr_q == `OFF_STATUS) ? `RESP_OKAY : `RESP_SLVERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            ctrl_q <= `CTRL_RESET;
        else if (progRst)
            ctrl_q <= `CTRL_RESET; // RULE11
        else if (doWrite && awAddr_q == `OFF_CTRL)
            for (int b = 0; b < 4; b++)
                if (wStrb_q[b])
                    ctrl_q[8*b +: 8] <= wData_q[8*b +: 8];
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= `RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `RESP_OKAY;
                case (s_axi_araddr[`ADDR_W-1:0])
                    `OFF_CTRL:   s_axi_rdata <= ctrl_q;
                    `OFF_STATUS: s_axi_rdata <= {29'h0, flags_q};
                    `OFF_LEVEL:  s_axi_rdata <= {27'h0, fifoLevel};
                    default:
                    begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `RESP_SLVERR;
                    end
                endcase
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst || dpRst);

    sequence s_untaken;
        outValid && !outReady;
    endsequence
    sequence s_skipped;
        !outValid ##0 skipNext_q;
    endsequence

    a_missing_sets: assert property (reqCycle && !waiting_q && inReady && !inValid && flagEn[0] // RULE1
        |=> missing_input_flag || dpRst) else $error("missing input not flagged");
    a_stall_holds: assert property (waiting_q && !inValid |=> waiting_q || dpRst) // RULE2
        else $error("input wait left early");
    a_fifo_room: assert property (inAccept |-> fifoWrReady) // RULE3
        else $error("sample taken with fifo full");
    a_flag_sticky: assert property (dropped_output_flag && flagEn[2] && flagClr[2] == 1'b0 // RULE4
        |=> dropped_output_flag || dpRst) else $error("flag dropped by itself");
    a_packet_err: assert property (inAccept && input_last_marker && !pktFinal && flagEn[1] // RULE5
        |=> packet_length_error_flag || dpRst) else $error("short packet not flagged");
    a_drop_flag: assert property (s_untaken ##0 flagEn[2] |=> dropped_output_flag || dpRst) // RULE6
        else $error("untaken output not flagged");
    a_drop_skip: assert property (s_untaken |=> s_skipped) // RULE7
        else $error("sample after untaken one not discarded");
    a_irq_or: assert property (combined_irq == (missing_input_flag || packet_length_error_flag // RULE8
        || dropped_output_flag)) else $error("combined irq not the OR of flags");
    a_disabled_low: assert property (!flagEn[0] |=> !missing_input_flag) // RULE12
        else $error("disabled flag high");
    a_clear_next: assert property (flagClr[1] && !flagSet[1] |=> !packet_length_error_flag) // RULE12
        else $error("cleared flag still high");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) // RULE11
        else $error("write response withdrawn");
endmodule

// *** bench/stream_partner.sv ***
// behavioural sample source and output sink facing the error-flag block
// assumes the bench steers stalls, marker mode and output refusal by NBA after mclk
`timescale 1ns/1ps
module stream_partner (
    input  wire logic        mclk,
    input  wire logic        rstN,
    input  wire logic        holdOff,
    input  wire logic [1:0]  markMode,
    input  wire logic        sinkStall,
    input  wire logic        inReady,
    output logic             inValid,
    output logic [15:0]      inData,
    output logic             lastMark,
    output logic             outReady
);
    logic [31:0] seed  = 32'h1c20_8748;
    logic [15:0] dataQ = 16'h0000;
    logic [1:0]  posQ  = 2'h0;

    // mode 0 marks the 4th sample, 1 marks too early, 2 never marks
    assign lastMark = (markMode == 2'h0) ? (posQ == 2'h3) : (markMode == 2'h1) && (posQ == 2'h1);
    assign inValid  = !holdOff;
    // any 16-bit pattern is a legal Q1.15 value; idle data shows the inverse
    assign inData   = inValid ? dataQ : ~dataQ;
    assign outReady = !sinkStall;

    always @(posedge mclk)
    begin
        if (!rstN)
            posQ <= 2'h0;
        else if (inValid && inReady)
        begin
            posQ  <= lastMark ? 2'h0 : posQ + 2'h1;
            dataQ <= 16'($random(seed));
        end
    end
endmodule

// *** bench/tb_top.sv ***
// self-checking bench for the stream error-flag block
// assumes the partner model on the stream side and an AXI4-Lite master here
`timescale 1ns/1ps
`include "stream_flags_defs.svh"
module tb_top
    import stream_flags_pkg::*;
;
    logic mclk = 0, sys_rst = 1, datapath_reset_n = 1, programming_reset_n = 1;
    logic inValid, inReady, input_last_marker, outValid, outReady, outLast, combined_irq;
    logic missing_input_flag, packet_length_error_flag, dropped_output_flag;
    logic [`IN_DATA_W-1:0] inData;
    logic [`OUT_DATA_W-1:0] outData;
    logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1, s_axi_arvalid = 0, s_axi_rready = 1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp, markMode = 0;
    logic holdOff = 1, sinkStall = 0;
    logic signed [3:0] expGain = 4'sh1;
    logic [20:0] expQ[$];
    int errCount = 0, nChecks = 0, skipPend = 0;

    always #5 mclk = ~mclk;

    converter_stream_error_flags DUT (.mclk, .sys_rst, .datapath_reset_n, .programming_reset_n,
        .inValid, .inReady, .inData, .input_last_marker, .outValid, .outReady, .outData, .outLast,
        .missing_input_flag, .packet_length_error_flag, .dropped_output_flag, .combined_irq,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    stream_partner partner (.mclk, .rstN(datapath_reset_n), .holdOff, .markMode, .sinkStall,
        .inReady, .inValid, .inData, .lastMark(input_last_marker), .outReady);

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        nChecks++;
        if (seen !== exp)
        begin
            errCount++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic axiWrite(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        r = s_axi_bresp;
    endtask

    task automatic axiRead(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask

    task automatic checkFlags(input flag_vec_type e);
        check("flags", {29'h0, dropped_output_flag, packet_length_error_flag, missing_input_flag}, {29'h0, e});
        check("irq", {31'h0, combined_irq}, {31'h0, |e});
    endtask

    task automatic clearFlags(input logic [31:0] m);
        axiWrite(`OFF_STATUS, m, rsp);
        cyc(1);
    endtask

    // reference model of the sample path
    always @(posedge mclk)
    begin
        if (inValid && inReady)
            expQ.push_back({input_last_marker, 20'($signed(20'($signed(inData))) * $signed(20'(expGain)))});
        if (outValid)
        begin
            if (skipPend != 0 && expQ.size() > 0)
                void'(expQ.pop_front());
            skipPend = 0;
            if (expQ.size() == 0)
                check("outQueue", 32'h1, 32'h0);
            else if (outReady)
                check("outSample", {11'h0, outLast, outData}, {11'h0, expQ.pop_front()});
            else
            begin
                void'(expQ.pop_front());
                skipPend = 1;
            end
        end
    end

    initial
    begin
        cyc(10);
        sys_rst <= 1'b0;
        cyc(10);
        axiRead(`OFF_CTRL, rd, rsp);
        check("ctrlReset", rd, `CTRL_RESET);
        axiRead(`OFF_STATUS, rd, rsp);
        check("statusMiss", rd, 32'h0000_0000);
        check("inReadyWait", {31'h0, inReady}, 32'h0000_0001);
        checkFlags(3'b000);
        axiRead(32'h0000_000c, rd, rsp);
        check("unmapRd", {rd[29:0], rsp}, {30'h0, `RESP_SLVERR});
        axiWrite(32'h0000_000c, 32'h0000_0000, rsp);
        check("unmapWr", {30'h0, rsp}, {30'h0, `RESP_SLVERR});
        axiWrite(`OFF_LEVEL, 32'h0000_0003, rsp);
        check("levelWr", {30'h0, rsp}, {30'h0, `RESP_SLVERR});
        axiWrite(`OFF_CTRL, 32'h0000_0087, rsp);
        expGain = 4'sh8;
        holdOff <= 1'b0;
        cyc(2);
        clearFlags(32'h0000_0007);
        checkFlags(3'b000);
        cyc(120);
        checkFlags(3'b000);
        holdOff <= 1'b1;
        cyc(10);
        check("inReadyHold", {31'h0, inReady}, 32'h0000_0001);
        holdOff <= 1'b0;
        cyc(60);
        checkFlags(3'b001);
        clearFlags(32'h0000_0001);
        markMode <= 2'h1;
        cyc(40);
        checkFlags(3'b010);
        markMode <= 2'h0;
        clearFlags(32'h0000_0002);
        cyc(40);
        checkFlags(3'b000);
        markMode <= 2'h2;
        cyc(40);
        checkFlags(3'b010);
        markMode <= 2'h0;
        clearFlags(32'h0000_0002);
        cyc(40);
        sinkStall <= 1'b1;
        do
            @(posedge mclk);
        while (!outValid);
        sinkStall <= 1'b0;
        cyc(30);
        checkFlags(3'b100);
        clearFlags(32'h0000_0004);
        axiWrite(`OFF_CTRL, 32'h0000_0080, rsp);
        holdOff <= 1'b1;
        cyc(12);
        checkFlags(3'b000);
        axiWrite(`OFF_CTRL, 32'h0000_0087, rsp);
        holdOff <= 1'b0;
        cyc(8);
        holdOff <= 1'b1;
        cyc(12);
        checkFlags(3'b001);
        axiWrite(`OFF_CTRL, 32'h0000_0086, rsp);
        cyc(1);
        checkFlags(3'b000);
        axiWrite(`OFF_CTRL, 32'h0000_0087, rsp);
        holdOff <= 1'b0;
        cyc(8);
        holdOff <= 1'b1;
        cyc(20);
        checkFlags(3'b001);
        datapath_reset_n <= 1'b0;
        cyc(8);
        expQ.delete();
        skipPend = 0;
        checkFlags(3'b000);
        axiRead(`OFF_LEVEL, rd, rsp);
        check("levelEmpty", rd, 32'h0000_0000);
        datapath_reset_n <= 1'b1;
        cyc(8);
        holdOff <= 1'b0;
        cyc(60);
        holdOff <= 1'b1;
        cyc(20);
        programming_reset_n <= 1'b0;
        cyc(6);
        programming_reset_n <= 1'b1;
        cyc(6);
        axiRead(`OFF_CTRL, rd, rsp);
        check("ctrlProgReset", rd, `CTRL_RESET);
        conclude();
    end

    initial
    begin
        cyc(20000);
        errCount++;
        conclude();
    end

    task automatic conclude();
        if (errCount == 0 && nChecks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
endmodule
